//--- touch_ctrl_consts.svh
// Named constants for the touch reset, sleep and pin-function control block.
// Assumes a 250 MHz core clock; every time is kept in its own unit beside its cycle count.
`ifndef TOUCH_CTRL_CONSTS_SVH
`define TOUCH_CTRL_CONSTS_SVH

`define CORE_CLK_MHZ          250
`define SENSE_PIN_COUNT       16
`define CYC_CNT_W             25

// Time from reset release until the device counts as settled
`define POWER_SETTLE_MS       100
`define POWER_SETTLE_CYC      (`POWER_SETTLE_MS * 1000 * `CORE_CLK_MHZ)

// Sensing period options, fastest first; the values are plain defaults
`define SCAN_PERIOD0_US       1000
`define SCAN_PERIOD1_US       5000
`define SCAN_PERIOD2_US       10000
`define SCAN_PERIOD3_US       20000
`define SCAN_PERIOD0_CYC      (`SCAN_PERIOD0_US * `CORE_CLK_MHZ)
`define SCAN_PERIOD1_CYC      (`SCAN_PERIOD1_US * `CORE_CLK_MHZ)
`define SCAN_PERIOD2_CYC      (`SCAN_PERIOD2_US * `CORE_CLK_MHZ)
`define SCAN_PERIOD3_CYC      (`SCAN_PERIOD3_US * `CORE_CLK_MHZ)

`define SYNC_ASSERTED         2'b00
`define PINS_CLEAR            16'h0000
`define CNT_ZERO              25'h000_0000
`define CNT_ONE               25'h000_0001

`endif

//--- touch_ctrl_pkg.sv
// Types shared by the touch reset, sleep and pin-function control block.
// Assumes the constants header is included by every user of this package.
`default_nettype none

package touch_ctrl_pkg;

    typedef enum logic [3:0] {
        ST_RESET  = 4'b0001,
        ST_SETTLE = 4'b0010,
        ST_RUN    = 4'b0100,
        ST_SLEEP  = 4'b1000
    } pwr_state_t;

    typedef enum logic [1:0] {
        PERIOD_FASTEST = 2'b00,
        PERIOD_FAST    = 2'b01,
        PERIOD_SLOW    = 2'b10,
        PERIOD_SLOWEST = 2'b11
    } scan_period_t;

    // Drive of the sixteen sense pins; led_oe high sinks the pin low
    typedef struct packed {
        logic [15:0] touch_en;
        logic [15:0] led_out;
        logic [15:0] led_oe;
    } sense_pin_drive_t;

    // Reset and clock controls handed to the rest of the device
    typedef struct packed {
        logic sys_rst_n;
        logic i2c_rst_n;
        logic sys_clk_en;
        logic ready;
    } core_ctrl_t;

endpackage : touch_ctrl_pkg

`default_nettype wire

//--- reset_input_sync.sv
// Two-stage synchroniser for the reset pin and the supply monitor flag.
// Assumes both inputs are asynchronous to the core clock; the POR resets it.
`default_nettype none
`include "touch_ctrl_consts.svh"

module reset_input_sync (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic [1:0] i_async,
    output logic      [1:0] o_sync
);

    logic [1:0] meta_r;

    // Resets to the asserted level so a reset source never glitches inactive
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            meta_r <= `SYNC_ASSERTED;
            o_sync <= `SYNC_ASSERTED;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule : reset_input_sync

`default_nettype wire

//--- touch_reset_sleep_mode_control.sv
// Reset combining, sleep control, sensing-period timing and sense pin function select.
// Assumes control bits come from the I2C register file on the same clock and that
// the reset pin and supply monitor flag are asynchronous.
`default_nettype none
`include "touch_ctrl_consts.svh"

module touch_reset_sleep_mode_control
    import touch_ctrl_pkg::*;
#(
    parameter int P_SETTLE_CYC  = `POWER_SETTLE_CYC,
    parameter int P_PERIOD0_CYC = `SCAN_PERIOD0_CYC,
    parameter int P_PERIOD1_CYC = `SCAN_PERIOD1_CYC,
    parameter int P_PERIOD2_CYC = `SCAN_PERIOD2_CYC,
    parameter int P_PERIOD3_CYC = `SCAN_PERIOD3_CYC
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_ext_rst_pin_n,
    input  wire logic             i_supply_ok,
    input  wire logic             i_sleep_req,
    input  wire scan_period_t     i_scan_period,
    input  wire logic [15:0]      i_led_mode,
    input  wire logic [15:0]      i_led_pwm,
    input  wire logic [15:0]      i_touch_raw,
    output core_ctrl_t            o_core,
    output logic                  o_rst_pin_pullup_en,
    output logic                  o_scan_tick,
    output logic [15:0]           o_touch_out,
    output sense_pin_drive_t      o_pin
);

    logic [1:0]            src_sync;
    logic                  any_rst;
    pwr_state_t            state_r;
    pwr_state_t            state_nxt;
    logic [`CYC_CNT_W-1:0] settle_cnt_r;
    logic [`CYC_CNT_W-1:0] scan_cnt_r;
    logic [`CYC_CNT_W-1:0] scan_len;
    logic                  settle_done;
    logic                  scan_wrap;
    logic                  running;

    reset_input_sync u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    ({i_supply_ok, i_ext_rst_pin_n}),
        .o_sync     (src_sync)
    );

    // Any source holds reset; release is a plain clocked state change
    assign any_rst = !i_rst_n || !src_sync[1] || !src_sync[0];

    // Pull-up stays on so a floating pin reads inactive
    always_ff @(posedge i_core_clk) begin
        o_rst_pin_pullup_en <= 1'b1;
    end

    assign settle_done = (settle_cnt_r == P_SETTLE_CYC[`CYC_CNT_W-1:0] - `CNT_ONE);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RESET: begin
                state_nxt = ST_SETTLE;
            end
            ST_SETTLE: begin
                if (settle_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (i_sleep_req) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!i_sleep_req) begin
                    state_nxt = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (any_rst) begin
            state_r <= ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Settling counter; runs once per reset and then parks
    always_ff @(posedge i_core_clk) begin
        if (any_rst || state_r != ST_SETTLE) begin
            settle_cnt_r <= `CNT_ZERO;
        end else if (!settle_done) begin
            settle_cnt_r <= settle_cnt_r + `CNT_ONE;
        end
    end

    // Reset outputs; the I2C slave is released with the system but ignores sleep
    always_ff @(posedge i_core_clk) begin
        if (any_rst) begin
            o_core <= '0;
        end else begin
            o_core.sys_rst_n  <= 1'b1;
            o_core.i2c_rst_n  <= 1'b1;
            o_core.sys_clk_en <= (state_nxt == ST_RUN) || (state_nxt == ST_SETTLE);
            o_core.ready      <= (state_nxt == ST_RUN) || (state_nxt == ST_SLEEP);
        end
    end

    // Sensing period select; a change applies to the period in progress, wrapping at once if the count already passes it
    always_comb begin
        scan_len = P_PERIOD0_CYC[`CYC_CNT_W-1:0];
        unique case (i_scan_period)
            PERIOD_FASTEST: scan_len = P_PERIOD0_CYC[`CYC_CNT_W-1:0];
            PERIOD_FAST:    scan_len = P_PERIOD1_CYC[`CYC_CNT_W-1:0];
            PERIOD_SLOW:    scan_len = P_PERIOD2_CYC[`CYC_CNT_W-1:0];
            PERIOD_SLOWEST: scan_len = P_PERIOD3_CYC[`CYC_CNT_W-1:0];
        endcase
    end

    assign running   = (state_r == ST_RUN);
    assign scan_wrap = (scan_cnt_r >= scan_len - `CNT_ONE);

    // Scan timer is held at zero in sleep and restarts from zero on wake
    always_ff @(posedge i_core_clk) begin
        if (any_rst || !running) begin
            scan_cnt_r <= `CNT_ZERO;
        end else if (scan_wrap) begin
            scan_cnt_r <= `CNT_ZERO;
        end else begin
            scan_cnt_r <= scan_cnt_r + `CNT_ONE;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (any_rst) begin
            o_scan_tick <= 1'b0;
        end else begin
            o_scan_tick <= running && scan_wrap && !i_sleep_req;
        end
    end

    // Touch result is taken per scan; LED pins are masked out
    always_ff @(posedge i_core_clk) begin
        if (any_rst) begin
            o_touch_out <= `PINS_CLEAR;
        end else if (running && scan_wrap) begin
            o_touch_out <= i_touch_raw & ~i_led_mode;
        end
    end

    // Per-pin function: at most one of touch enable or LED sink can be active
    genvar gi;
    generate
        for (gi = 0; gi < `SENSE_PIN_COUNT; gi++) begin : g_pin
            always_ff @(posedge i_core_clk) begin
                if (any_rst || state_nxt != ST_RUN) begin
                    o_pin.touch_en[gi] <= 1'b0;
                    o_pin.led_oe[gi]   <= 1'b0;
                    o_pin.led_out[gi]  <= 1'b0;
                end else begin
                    o_pin.touch_en[gi] <= !i_led_mode[gi];
                    o_pin.led_oe[gi]   <= i_led_mode[gi] && i_led_pwm[gi];
                    o_pin.led_out[gi]  <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : touch_reset_sleep_mode_control

`default_nettype wire

//--- touch_reset_sleep_mode_control_properties.sv
// Checker on the ports of the touch reset, sleep and pin-function block.
// Assumes the bench sets the fastest sensing period to 8 cycles.
`default_nettype none
module touch_ctrl_checker
    import touch_ctrl_pkg::*;
(
    input wire logic             i_core_clk,
    input wire logic             i_rst_n,
    input wire logic             i_ext_rst_pin_n,
    input wire logic             i_supply_ok,
    input wire logic             i_sleep_req,
    input wire scan_period_t     i_scan_period,
    input wire logic [15:0]      i_led_mode,
    input wire logic [15:0]      i_led_pwm,
    input wire logic [15:0]      i_touch_raw,
    input wire core_ctrl_t       o_core,
    input wire logic             o_rst_pin_pullup_en,
    input wire logic             o_scan_tick,
    input wire logic [15:0]      o_touch_out,
    input wire sense_pin_drive_t o_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    pullup_on_a: assert property (o_rst_pin_pullup_en)
        else $error("pull-up enable low");
    pin_reset_a: assert property (!i_ext_rst_pin_n [*4] |=> o_core == '0)
        else $error("reset pin did not reset");
    supply_reset_a: assert property (!i_supply_ok [*4] |=> o_core == '0)
        else $error("supply drop did not reset");
    pin_excl_a: assert property ((o_pin.touch_en & o_pin.led_oe) == '0 && o_pin.led_out == '0)
        else $error("pin both touch and led");
    sleep_stop_a: assert property (o_core.ready && i_sleep_req |=> !o_core.sys_clk_en && o_pin == '0)
        else $error("sleep left clocks or pins on");
    i2c_awake_a: assert property (o_core.sys_rst_n && !o_core.sys_clk_en |-> o_core.i2c_rst_n)
        else $error("i2c held in reset in sleep");
    wake_up_a: assert property (o_core.sys_rst_n && !o_core.sys_clk_en && !i_sleep_req
        |=> o_core.sys_clk_en || !o_core.sys_rst_n) else $error("no wake on cleared bit");
    tick_gap_a: assert property (o_scan_tick && i_scan_period == PERIOD_FASTEST
        |=> !o_scan_tick [*7]) else $error("scan ticks too close");
    touch_mask_a: assert property (o_scan_tick
        |-> o_touch_out == ($past(i_touch_raw) & ~$past(i_led_mode))) else $error("touch result");
    pin_select_a: assert property (o_core.ready && o_core.sys_clk_en && !i_sleep_req |=>
        !o_core.sys_rst_n || (o_pin.touch_en == ~$past(i_led_mode)
        && o_pin.led_oe == ($past(i_led_mode) & $past(i_led_pwm)))) else $error("pin select");
    sleep_c: cover property (o_core.sys_rst_n && !o_core.sys_clk_en);
    tick_c: cover property (o_scan_tick && o_touch_out != '0);
    led_c: cover property (o_pin.led_oe != '0);
endmodule : touch_ctrl_checker
bind touch_reset_sleep_mode_control touch_ctrl_checker touch_ctrl_checker_inst (.i_core_clk,
    .i_rst_n, .i_ext_rst_pin_n, .i_supply_ok, .i_sleep_req, .i_scan_period, .i_led_mode,
    .i_led_pwm, .i_touch_raw, .o_core, .o_rst_pin_pullup_en, .o_scan_tick, .o_touch_out, .o_pin);
`default_nettype wire

//--- host_rst_model.sv
// Host side of the reset pin: pulls it low on request, else drives it high.
// Assumes the device pull-up holds the released line high.
`default_nettype none
module host_rst_model #(
    parameter int P_LOW_CYC = 2600
) (
    input  wire logic i_core_clk,
    input  wire logic i_go,
    output logic      o_pin_n
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt_r = 0;
    // 2600 cycles at 4 ns stays past the 10 us minimum
    always @(posedge i_core_clk) begin
        if (i_go) begin
            cnt_r <= P_LOW_CYC;
        end else if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
        end
    end
    assign o_pin_n = (cnt_r == 0);
endmodule : host_rst_model
`default_nettype wire

//--- test_touch_reset_sleep_mode_control.sv
// Self-checking bench for the touch reset, sleep and pin-function block.
// Assumes shortened settle and period parameters set at the instance below.
`default_nettype none
module test_touch_reset_sleep_mode_control
    import touch_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic             clk = 0, rst_n = 0, sup_ok = 1, sleep = 0, go = 0, pin_n, pu, tick;
    scan_period_t     per = PERIOD_FASTEST;
    logic [15:0]      mode = '0, pwm = '0, raw = '0, tout, note_q[$];
    core_ctrl_t       core;
    sense_pin_drive_t pin;
    int               error_cnt = 0, comparisons = 0, cyc = 0, seed = 32'hdfaa, t0 = 0;
    always #2 clk = ~clk;
    host_rst_model host_rst_model_inst (.i_core_clk(clk), .i_go(go), .o_pin_n(pin_n));
    touch_reset_sleep_mode_control #(.P_SETTLE_CYC(20), .P_PERIOD0_CYC(8), .P_PERIOD1_CYC(16),
        .P_PERIOD2_CYC(32), .P_PERIOD3_CYC(64)) touch_reset_sleep_mode_control_inst (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_ext_rst_pin_n(pin_n), .i_supply_ok(sup_ok),
        .i_sleep_req(sleep), .i_scan_period(per), .i_led_mode(mode), .i_led_pwm(pwm),
        .i_touch_raw(raw), .o_core(core), .o_rst_pin_pullup_en(pu), .o_scan_tick(tick),
        .o_touch_out(tout), .o_pin(pin));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    task automatic settle();
        for (int n = 0; n < 100 && core.ready !== 1'b1; n++) @(negedge clk);
        chk(core, 4'hf, "settled");
    endtask : settle
    task automatic wait_tick();
        @(negedge clk);
        for (int n = 0; n < 200 && tick !== 1'b1; n++) @(negedge clk);
        chk(tick, 1'b1, "tick");
    endtask : wait_tick
    // Sampled after the edge so the registered tick and result have landed
    always @(posedge clk) begin
        #1;
        if (tick === 1'b1 && note_q.size() > 0) chk(tout, note_q.pop_front(), "touch");
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("MISMATCH t=%0t timeout", $time);
            summarize();
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        chk({pu, core}, 5'h10, "in reset");
        rst_n = 1;
        settle();
        $display("test power-up done");
        for (int k = 0; k < 8; k++) begin
            wait_tick();
            // Gap since the last tick is the period chosen one tick earlier
            if (k > 0) chk(cyc - t0, 8 << ((k - 1) % 4), "period");
            t0 = cyc;
            per = scan_period_t'(k % 4);
            {mode, pwm} = $random(seed);
            raw = 16'($random(seed));
            note_q.push_back(raw & ~mode);
            @(negedge clk);
            chk(pin, {~mode, 16'h0, mode & pwm}, "pin");
        end
        wait_tick();
        chk(cyc - t0, 8 << 3, "period");
        $display("test scan and pins done");
        sleep = 1;
        @(negedge clk);
        chk({core.i2c_rst_n, core.sys_clk_en, pin}, {2'b10, 48'h0}, "sleep");
        repeat (70) @(negedge clk);
        sleep = 0;
        @(negedge clk);
        chk(core.sys_clk_en, 1'b1, "wake");
        wait_tick();
        $display("test sleep done");
        go = 1;
        @(negedge clk);
        go = 0;
        repeat (5) @(negedge clk);
        chk(core, 4'h0, "pin reset");
        for (int n = 0; n < 3000 && pin_n !== 1'b1; n++) @(negedge clk);
        settle();
        sup_ok = 0;
        repeat (5) @(negedge clk);
        chk(core, 4'h0, "supply low");
        sup_ok = 1;
        settle();
        $display("test resets done");
        summarize();
    end
endmodule : test_touch_reset_sleep_mode_control
`default_nettype wire
